/* File: core/scr_pkg.sv */
// constants and types for the system control word
package scr_pkg;
	// coprocessor selector values for this register
	localparam logic [3:0] SCR_SEC_REG = 4'h0;
	localparam logic [2:0] SCR_OPC2    = 3'h0;
	// field positions
	localparam int SCR_BIT_MMU   = 0;
	localparam int SCR_BIT_ALIGN = 1;
	localparam int SCR_BIT_DC    = 2;
	localparam int SCR_BIT_ROMP  = 9;
	localparam int SCR_BIT_SYSP  = 8;
	localparam int SCR_BIT_PFP   = 11;
	localparam int SCR_BIT_IC    = 12;
	localparam int SCR_BIT_VEC   = 13;
	localparam int SCR_BIT_ONE14 = 14;
	localparam int SCR_BIT_PCK   = 15;
	localparam int SCR_BIT_UNAL  = 22;
	localparam int SCR_BIT_XPF   = 23;
	localparam int SCR_BIT_EBO   = 25;
	localparam int SCR_BIT_FIU   = 27;
	localparam int SCR_BIT_RMP   = 28;
	localparam int SCR_BIT_AFF   = 29;
	// bits 6:3 read as one, 21:16 fixed pattern
	localparam logic [3:0]  SCR_SBO_6_3   = 4'hf;
	localparam logic [5:0]  SCR_FIX_21_16 = 6'h05;
	// bits that software can change
	localparam logic [31:0] SCR_WR_MASK   = 32'h3ac0bb07;
	// constant bits always read
	localparam logic [31:0] SCR_RO_ONES   = 32'h00054078;
	// vector bases
	localparam logic [31:0] SCR_VEC_LOW   = 32'h00000000;
	localparam logic [31:0] SCR_VEC_HIGH  = 32'hffff0000;
	localparam logic [31:0] SCR_VEC_LAST  = 32'h0000001c;
	// endian configuration pin codes
	localparam logic [1:0]  SCR_CFG_LE    = 2'h0;
	localparam logic [1:0]  SCR_CFG_RSV   = 2'h1;
	localparam logic [1:0]  SCR_CFG_UNAL  = 2'h2;
	localparam logic [1:0]  SCR_CFG_BE8   = 2'h3;
	// alignment check modulus
	localparam logic [2:0]  SCR_MOD8_MASK = 3'h7;
	localparam logic [2:0]  SCR_MOD4_MASK = 3'h3;

	// alignment behaviour decoded from the control word
	typedef enum logic [1:0] {
		SCR_AL_ROTATE = 2'b00,
		SCR_AL_UNAL   = 2'b01,
		SCR_AL_ABORT  = 2'b10
	} scr_align_t;

	// decoded controls handed to the core
	typedef struct packed {
		logic        mmuEn;
		logic        dcacheEn;
		logic        icacheEn;
		logic        flowPredEn;
		logic        strictAlign;
		logic        highVectors;
		logic [31:0] vectorBase;
		logic        pcLoadStateKeep;
		logic        extendedPageFormat;
		logic        fastIrqUnmaskable;
		logic        regionAttrRemap;
		logic        accessFlagFaultForce;
		logic        exceptionByteOrder;
		logic        dataBigEndian8;
		logic        instrLittleEndian;
		logic        reservedCombo;
	} scr_ctrl_t;

	// one coprocessor move toward the register
	typedef struct packed {
		logic        valid;
		logic        write;
		logic        privileged;
		logic [3:0]  secReg;
		logic [2:0]  opc2;
		logic [31:0] wdata;
	} scr_cop_req_t;
endpackage

/* File: core/scr_system_control.sv */
// system control word with its decoded controls
//
// Summary of operation
// - 32-bit, privileged moves with selectors zero
// - defined fields reset zero except pin-driven ones
// - vector bit resets from high-vector pin
// - endian pins set exception, unaligned, data-endian
// - U,A,E clear: little-endian, rotated loads
// - A set, U clear: abort, modulo 8
// - U and A set: modulo 4 checks
// - bit 22 permits unaligned, mixed endian
// - bit 29 forces access-flag faults
// - bit 28 enables attribute remapping
// - bit 27 makes fast interrupts unmaskable
// - exception copies bit 25 into data-endian
// - bit 23 disables subpage permission bits
// - bits 21:16 fixed 000101, writes ignored
// - bit 15 keeps state on PC loads
// - bit 13 selects high vector base
// - bit 1 strict alignment overrides bit 22
// - bits 12,11,2,0 cache, predict, MMU enables
`timescale 1ns/100ps
module scr_system_control (
	input  wire logic                 clk,                 // processor clock
	input  wire logic                 rst,                 // synchronous reset, high
	input  wire logic                 high_vector_init_pin,// vector strap
	input  wire logic [1:0]           endian_config_pins,  // endian strap pair
	input  wire scr_pkg::scr_cop_req_t copReq,             // coprocessor move
	input  wire logic                 exceptionTaken,      // exception entry pulse
	input  wire logic                 statusEndianIn,      // current data-endian state
	input  wire logic                 statusEndianWr,      // core writes data-endian
	input  wire logic [2:0]           accessAddrLow,       // low data address bits
	input  wire logic [1:0]           accessSizeLog2,      // 0 byte .. 3 doubleword
	input  wire logic                 accessValid,         // data access probe
	output logic [31:0]               copRdata,            // read data of the move
	output logic                      copRdValid,          // read data valid pulse
	output logic                      copUndef,            // move refused pulse
	output logic                      current_status_word_e, // data-endian status bit
	output logic                      alignAbort,          // misaligned data abort
	output logic                      rotatedLoad,         // legacy rotate needed
	output scr_pkg::scr_ctrl_t        ctrl                 // decoded controls
);
	// stored writable bits only; constant bits added on read
	logic [31:0] word_r;
	logic [31:0] word_nxt;
	logic        endian_r;
	logic        endian_nxt;

	// address of this register selected by the move
	wire selHit   = copReq.valid && copReq.secReg == scr_pkg::SCR_SEC_REG && copReq.opc2 == scr_pkg::SCR_OPC2;
	wire accessOk = selHit && copReq.privileged;
	wire wrHit    = accessOk && copReq.write;
	wire rdHit    = accessOk && !copReq.write;
	// unprivileged attempts are refused and change nothing
	wire refuse   = selHit && !copReq.privileged;

	// fixed bits ignore writes, reserved read zero or one
	wire [31:0] readWord = (word_r & scr_pkg::SCR_WR_MASK) | scr_pkg::SCR_RO_ONES;

	// reset value of exception, unaligned and data-endian bits
	// the reserved code 01 is treated like 00, a safe little-endian start
	wire cfgBig   = endian_config_pins == scr_pkg::SCR_CFG_BE8;
	wire cfgUnal  = endian_config_pins == scr_pkg::SCR_CFG_UNAL || cfgBig;

	// reset image, only pin-driven fields can be nonzero
	// vector bit follows the high-vector pin
	// bit 25 exception order, bit 22 unaligned, bit 13 vectors
	wire [31:0] resetWord = {6'h00, cfgBig, 2'h0, cfgUnal, 8'h00, high_vector_init_pin, 13'h0000};

	// partial writes are not offered, software merges itself
	assign word_nxt = wrHit ? (copReq.wdata & scr_pkg::SCR_WR_MASK) : word_r;

	// exception entry copies bit 25; it beats a core write
	assign endian_nxt = exceptionTaken ? word_r[scr_pkg::SCR_BIT_EBO] :
	                    statusEndianWr ? statusEndianIn : endian_r;

	// register and status bit; straps sampled while reset is held
	always_ff @(posedge clk) begin
		if (rst) begin
			word_r   <= resetWord;
			endian_r <= cfgBig;
		end else begin
			word_r   <= word_nxt;
			endian_r <= endian_nxt;
		end
	end

	// decoded fields of the stored word
	wire fU = word_r[scr_pkg::SCR_BIT_UNAL];
	wire fA = word_r[scr_pkg::SCR_BIT_ALIGN];
	wire fE = endian_r;

	wire scr_pkg::scr_align_t mode = fA ? scr_pkg::SCR_AL_ABORT :
	                                 fU ? scr_pkg::SCR_AL_UNAL : scr_pkg::SCR_AL_ROTATE;

	// misalignment of an access of the given size under a mask
	function automatic logic misaligned(input logic [2:0] addr, input logic [2:0] msk);
		misaligned = |(addr & msk);
	endfunction

	// natural alignment mask for the item size, capped by modulus
	function automatic logic [2:0] sizeMask(input logic [1:0] sz, input logic [2:0] cap);
		logic [2:0] m;
		m = 3'h0;
		unique case (sz)
			2'h0: m = 3'h0;
			2'h1: m = 3'h1;
			2'h2: m = 3'h3;
			2'h3: m = 3'h7;
		endcase
		sizeMask = m & cap;
	endfunction

	// without U doublewords checked modulo 8
	// with U doublewords checked modulo 4
	wire [2:0] capMask  = fU ? scr_pkg::SCR_MOD4_MASK : scr_pkg::SCR_MOD8_MASK;
	wire       abortNxt = accessValid && mode == scr_pkg::SCR_AL_ABORT &&
	                      misaligned(accessAddrLow, sizeMask(accessSizeLog2, capMask));
	wire       rotNxt   = accessValid && mode == scr_pkg::SCR_AL_ROTATE && accessSizeLog2 == 2'h2 &&
	                      misaligned(accessAddrLow, scr_pkg::SCR_MOD4_MASK);

	// decoded controls, built combinationally and then registered
	scr_pkg::scr_ctrl_t ctrlNxt;
	always_comb begin
		ctrlNxt = '0;
		ctrlNxt.mmuEn                = word_nxt[scr_pkg::SCR_BIT_MMU];
		ctrlNxt.dcacheEn             = word_nxt[scr_pkg::SCR_BIT_DC];
		ctrlNxt.icacheEn             = word_nxt[scr_pkg::SCR_BIT_IC];
		ctrlNxt.flowPredEn           = word_nxt[scr_pkg::SCR_BIT_PFP];
		ctrlNxt.strictAlign          = word_nxt[scr_pkg::SCR_BIT_ALIGN];
		ctrlNxt.highVectors          = word_nxt[scr_pkg::SCR_BIT_VEC];
		ctrlNxt.vectorBase           = word_nxt[scr_pkg::SCR_BIT_VEC] ? scr_pkg::SCR_VEC_HIGH : scr_pkg::SCR_VEC_LOW;
		// keep compact state on PC loads
		ctrlNxt.pcLoadStateKeep      = word_nxt[scr_pkg::SCR_BIT_PCK];
		// subpage permission bits off when set
		ctrlNxt.extendedPageFormat   = word_nxt[scr_pkg::SCR_BIT_XPF];
		ctrlNxt.fastIrqUnmaskable    = word_nxt[scr_pkg::SCR_BIT_FIU];
		ctrlNxt.regionAttrRemap      = word_nxt[scr_pkg::SCR_BIT_RMP];
		ctrlNxt.accessFlagFaultForce = word_nxt[scr_pkg::SCR_BIT_AFF];
		// order copied into status on exception
		ctrlNxt.exceptionByteOrder   = word_nxt[scr_pkg::SCR_BIT_EBO];
		// data endian from status, instructions always little
		ctrlNxt.dataBigEndian8       = endian_nxt;
		ctrlNxt.instrLittleEndian    = 1'b1;
		// U and A clear with E set is a reserved combination
		ctrlNxt.reservedCombo        = endian_nxt && !word_nxt[scr_pkg::SCR_BIT_UNAL] &&
		                               !word_nxt[scr_pkg::SCR_BIT_ALIGN];
	end

	// reset image of the decoded controls, same as resetWord decode
	scr_pkg::scr_ctrl_t ctrlRst;
	always_comb begin
		ctrlRst                   = '0;
		ctrlRst.highVectors       = high_vector_init_pin;
		ctrlRst.vectorBase        = high_vector_init_pin ? scr_pkg::SCR_VEC_HIGH : scr_pkg::SCR_VEC_LOW;
		ctrlRst.exceptionByteOrder = cfgBig;
		ctrlRst.dataBigEndian8    = cfgBig;
		ctrlRst.instrLittleEndian = 1'b1;
	end

	// registered outputs; access probes answer one cycle later
	always_ff @(posedge clk) begin
		if (rst) begin
			copRdata              <= 32'h00000000;
			copRdValid            <= 1'b0;
			copUndef              <= 1'b0;
			current_status_word_e <= cfgBig;
			alignAbort            <= 1'b0;
			rotatedLoad           <= 1'b0;
			ctrl                  <= ctrlRst;
		end else begin
			copRdata              <= rdHit ? readWord : 32'h00000000;
			copRdValid            <= rdHit;
			copUndef              <= refuse;
			current_status_word_e <= endian_nxt;
			alignAbort            <= abortNxt;
			rotatedLoad           <= rotNxt;
			ctrl                  <= ctrlNxt;
		end
	end
endmodule

/* File: verif/scr_system_control_asserts.sv */
// port assertions for the system control word
`timescale 1ns/100ps
module scr_system_control_asserts (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic                  high_vector_init_pin,
	input wire logic [1:0]            endian_config_pins,
	input wire scr_pkg::scr_cop_req_t copReq,
	input wire logic                  exceptionTaken,
	input wire logic                  statusEndianIn,
	input wire logic                  statusEndianWr,
	input wire logic [2:0]            accessAddrLow,
	input wire logic [1:0]            accessSizeLog2,
	input wire logic                  accessValid,
	input wire logic [31:0]           copRdata,
	input wire logic                  copRdValid,
	input wire logic                  copUndef,
	input wire logic                  current_status_word_e,
	input wire logic                  alignAbort,
	input wire logic                  rotatedLoad,
	input wire scr_pkg::scr_ctrl_t    ctrl
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// a move aimed at this register
	wire selHit = copReq.valid && copReq.secReg == 4'h0 && copReq.opc2 == 3'h0;
	read_value_a:
	assert property (selHit && !copReq.write && copReq.privileged |=> copRdValid
		&& (copRdata & ~32'h3ac0bb07) == 32'h00054078) else $error("fixed read bits wrong");
	refuse_move_a:
	assert property (selHit && !copReq.privileged |=> copUndef && !copRdValid) else $error("unprivileged move not refused");
	write_fields_a:
	assert property (selHit && copReq.write && copReq.privileged |=> ctrl.accessFlagFaultForce == $past(copReq.wdata[29])
		&& ctrl.regionAttrRemap == $past(copReq.wdata[28]) && ctrl.fastIrqUnmaskable == $past(copReq.wdata[27]))
		else $error("written fields not applied");
	vec_base_a:
	assert property (ctrl.vectorBase == (ctrl.highVectors ? 32'hffff0000 : 32'h0)) else $error("vector base wrong");
	exc_copy_a:
	assert property (exceptionTaken |=> current_status_word_e == $past(ctrl.exceptionByteOrder)) else $error("endian copy wrong");
	strict_abort_a:
	assert property (accessValid && ctrl.strictAlign && accessSizeLog2 == 2'h2 && accessAddrLow[1:0] != 2'h0
		|=> alignAbort) else $error("misaligned word not aborted");
	free_access_a:
	assert property (accessValid && !ctrl.strictAlign |=> !alignAbort) else $error("abort without strict check");
	strap_vec_a:
	assert property ($fell(rst) |-> ctrl.highVectors == $past(high_vector_init_pin)) else $error("vector strap lost");
	instr_le_a:
	assert property (ctrl.instrLittleEndian) else $error("instruction order not little");
endmodule
bind scr_system_control scr_system_control_asserts chk (.clk(clk), .rst(rst),
	.high_vector_init_pin(high_vector_init_pin), .endian_config_pins(endian_config_pins), .copReq(copReq),
	.exceptionTaken(exceptionTaken), .statusEndianIn(statusEndianIn), .statusEndianWr(statusEndianWr),
	.accessAddrLow(accessAddrLow), .accessSizeLog2(accessSizeLog2), .accessValid(accessValid),
	.copRdata(copRdata), .copRdValid(copRdValid), .copUndef(copUndef),
	.current_status_word_e(current_status_word_e), .alignAbort(alignAbort), .rotatedLoad(rotatedLoad), .ctrl(ctrl));

/* File: verif/system_control_register_bench.sv */
// self-checking bench for the system control word
`timescale 1ns/100ps
module system_control_register_bench;
	logic                  clk = 1'b0;
	logic                  rst = 1'b1;
	logic                  vinit = 1'b0;   // vector strap
	logic [1:0]            cfg = 2'h0;     // endian straps
	scr_pkg::scr_cop_req_t copReq = '0;
	logic                  exc = 1'b0;
	logic                  endIn = 1'b0;
	logic                  endWr = 1'b0;
	logic [2:0]            addr = 3'h0;
	logic [1:0]            size = 2'h0;
	logic                  probeV = 1'b0;
	logic [31:0]           copRdata;
	logic                  copRdValid, copUndef, statusE, alignAbort, rotatedLoad;
	scr_pkg::scr_ctrl_t    ctrl;
	int                    n_errors = 0;
	int                    tests_run = 0;
	int                    cycles = 0;
	// enables gathered for one compare
	wire [8:0] ctrlBits = {ctrl.accessFlagFaultForce, ctrl.regionAttrRemap, ctrl.fastIrqUnmaskable,
		ctrl.extendedPageFormat, ctrl.pcLoadStateKeep, ctrl.icacheEn, ctrl.flowPredEn, ctrl.dcacheEn, ctrl.mmuEn};
	scr_system_control dut (.clk(clk), .rst(rst), .high_vector_init_pin(vinit), .endian_config_pins(cfg),
		.copReq(copReq), .exceptionTaken(exc), .statusEndianIn(endIn), .statusEndianWr(endWr),
		.accessAddrLow(addr), .accessSizeLog2(size), .accessValid(probeV), .copRdata(copRdata),
		.copRdValid(copRdValid), .copUndef(copUndef), .current_status_word_e(statusE),
		.alignAbort(alignAbort), .rotatedLoad(rotatedLoad), .ctrl(ctrl));
	always #5 clk = ~clk;
	// hang guard, far above the roughly 130 cycles needed
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			n_errors++;
			wrap_up();
		end
	end
	task automatic wrap_up();
		$display("compares %0d mismatches %0d", tests_run, n_errors);
		if (n_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// one move, held for one edge; pulses of that edge are readable on return
	task automatic move(input logic wr, input logic pr, input logic [3:0] sel, input logic [31:0] wd);
		@(negedge clk);
		copReq = '{1'b1, wr, pr, sel, 3'h0, wd};
		@(negedge clk);
		copReq.valid = 1'b0;
	endtask
	task automatic rdchk(input logic [31:0] exp);
		move(1'b0, 1'b1, 4'h0, 32'h0);
		check(copRdata, exp);
		check(copRdValid, 32'h1);
	endtask
	task automatic do_reset(input logic [1:0] c);
		cfg = c;
		vinit = c[0];
		rst = 1'b1;
		repeat (20) @(negedge clk);
		rst = 1'b0;
	endtask
	task automatic probe(input logic [2:0] a, input logic [1:0] s, input logic ab, input logic ro);
		@(negedge clk);
		{addr, size, probeV} = {a, s, 1'b1};
		@(negedge clk);
		probeV = 1'b0;
		check(alignAbort, ab);
		check(rotatedLoad, ro);
	endtask
	task automatic pulse(input logic e, input logic w, input logic v);
		@(negedge clk);
		{exc, endWr, endIn} = {e, w, v};
		@(negedge clk);
		{exc, endWr} = 2'h0;
	endtask
	initial begin
		// every strap pair, the reserved one read like 00
		for (int c = 0; c < 4; c++) begin
			do_reset(c[1:0]);
			rdchk(32'h00054078 | (32'(c[0]) << 13) | (32'(c[1]) << 22) | (32'(c[0] & c[1]) << 25));
			check(statusE, 32'(c[0] & c[1]));
			check(ctrl.highVectors, 32'(c[0]));
		end
		$display("reset test done");
		move(1'b1, 1'b1, 4'h0, 32'hffffffff);
		check(ctrl.vectorBase, 32'hffff0000);
		check(ctrlBits, 32'h1ff);
		rdchk(32'h3ac5fb7f);
		move(1'b1, 1'b0, 4'h0, 32'h0);
		check(copUndef, 32'h1);
		move(1'b1, 1'b1, 4'h1, 32'h0);
		rdchk(32'h3ac5fb7f);
		move(1'b1, 1'b1, 4'h0, 32'h0);
		check(ctrl.vectorBase, 32'h0);
		check(ctrlBits, 32'h0);
		rdchk(32'h00054078);
		$display("access test done");
		// exception copy beats a core write in the same cycle
		move(1'b1, 1'b1, 4'h0, 32'h02000000);
		pulse(1'b1, 1'b1, 1'b0);
		check(statusE, 32'h1);
		check(ctrl.dataBigEndian8, 32'h1);
		check(ctrl.exceptionByteOrder, 32'h1);
		check(ctrl.reservedCombo, 32'h1);
		move(1'b1, 1'b1, 4'h0, 32'h0);
		pulse(1'b0, 1'b1, 1'b1);
		pulse(1'b1, 1'b0, 1'b0);
		check(statusE, 32'h0);
		$display("exception test done");
		move(1'b1, 1'b1, 4'h0, 32'h2);
		probe(3'h2, 2'h2, 1'b1, 1'b0);
		probe(3'h4, 2'h3, 1'b1, 1'b0);
		move(1'b1, 1'b1, 4'h0, 32'h00400002);
		probe(3'h4, 2'h3, 1'b0, 1'b0);
		probe(3'h1, 2'h1, 1'b1, 1'b0);
		move(1'b1, 1'b1, 4'h0, 32'h0);
		probe(3'h1, 2'h2, 1'b0, 1'b1);
		move(1'b1, 1'b1, 4'h0, 32'h00400000);
		probe(3'h1, 2'h2, 1'b0, 1'b0);
		check(ctrl.instrLittleEndian, 32'h1);
		$display("alignment test done");
		wrap_up();
	end
endmodule
